/* dv/afsr_regs_monitor.sv */
// afsr_regs_monitor: port-level checks of the fault and status bank.
// assumes it is bound onto afsr_regs and sees only its ports.
`default_nettype none
module afsr_regs_monitor
  import afsr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        overcurrent_in,
  input wire logic        overheat_warning_in,
  input wire logic        sample_valid,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] sample_out,
  input wire logic [5:0]  gain_cut_eighth_db,
  input wire logic        amp_enable,
  input wire logic        retry_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // 8 cycles covers the 3-flop input filter plus the latch
  sequence s_oc_held; overcurrent_in [*8]; endsequence
  sequence s_warn_held; overheat_warning_in [*8]; endsequence
  sequence s_rd_cond; reg_rd && reg_addr == ADDR_CONDITION; endsequence
  property p_oc_off; s_oc_held |-> !amp_enable; endproperty
  property p_oc_flag; s_oc_held ##0 s_rd_cond |=> reg_rdata[ST_OC]; endproperty
  property p_warn_flag; s_warn_held ##0 s_rd_cond |=> reg_rdata[ST_OT_WARN]; endproperty
  property p_no_cut; !overheat_warning_in [*8] |-> gain_cut_eighth_db == CUT_00; endproperty
  property p_trig_zero; reg_rd && reg_addr == ADDR_FAULT_CTRL |=> !reg_rdata[FC_MANUAL];
  endproperty
  property p_unmapped; reg_rd && (reg_addr < ADDR_CLIP_LEVEL || reg_addr > ADDR_SUPPLY)
    |=> reg_rdata == 8'h00; endproperty
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_pulse; retry_strobe |=> !retry_strobe; endproperty
  // 127 is the smallest clip limit, so samples up to it pass untouched
  property p_small; sample_valid && sample_in < 16'h0080 |=> sample_out == $past(sample_in);
  endproperty
  property p_sign; sample_valid |=> sample_out[15] == $past(sample_in[15]); endproperty
  a_oc_off: assert property (p_oc_off) else $error("amp on in overcurrent");
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag low");
  a_warn_flag: assert property (p_warn_flag) else $error("warning flag low");
  a_no_cut: assert property (p_no_cut) else $error("gain cut without warning");
  a_trig_zero: assert property (p_trig_zero) else $error("trigger reads 1");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_pulse: assert property (p_pulse) else $error("retry pulse too long");
  a_small: assert property (p_small) else $error("small sample altered");
  a_sign: assert property (p_sign) else $error("clip changed sign");
endmodule
bind afsr_regs afsr_regs_monitor afsr_regs_monitor_inst (.*);
`default_nettype wire

/* dv/amp_fault_status_regs_tb_top.sv */
// amp_fault_status_regs_tb_top: self-checking bench for afsr_regs.
// assumes afsr_pkg and the bound monitor are compiled first.
`default_nettype none
module amp_fault_status_regs_tb_top
  import afsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, temp_code_in = 8'h00, supply_code_in = 8'h00;
  logic        regulator_undervolt_in = 1'b0, power_stage_undervolt_in = 1'b0;
  logic        overcurrent_in = 1'b0, overheat_fault_in = 1'b0, overheat_warning_in = 1'b0;
  logic        limiter_active_in = 1'b0, low_battery_in = 1'b0;
  logic [15:0] sample_in = 16'h0000, sample_out;
  logic [7:0]  reg_rdata;
  logic [5:0]  gain_cut_eighth_db;
  logic        amp_enable, retry_strobe;
  int          err_total = 0, samples_checked = 0, pulses = 0;
  afsr_regs afsr_regs_inst (.*);
  always #50 clk = ~clk;
  always @(posedge clk) if (retry_strobe === 1'b1) pulses++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes drop for a full cycle so back-to-back calls never re-drive in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk({8'h00, reg_rdata}, {8'h00, exp});
    cyc(1);
  endtask
  function automatic logic [5:0] cut(input int g);
    case (g)
      0: return CUT_00;
      1: return CUT_01;
      2: return CUT_10;
      default: return CUT_11;
    endcase
  endfunction
  function automatic logic [16:0] clipf(input logic [7:0] lv, input logic [15:0] s);
    int lim;
    int v;
    lim = (int'(lv) + 1) * 128 - 1;
    v = int'($signed(s));
    if (v > lim)
      return {1'b1, 16'(lim)};
    if (v < -lim)
      return {1'b1, 16'(-lim)};
    return {1'b0, s};
  endfunction
  // fault 0 overcurrent, 1 overheat, 2 both undervoltages
  task automatic ep(input int i, input logic en);
    overcurrent_in = (i == 0);
    overheat_fault_in = (i == 1);
    regulator_undervolt_in = (i == 2);
    power_stage_undervolt_in = (i == 2);
    cyc(8);
    chk({15'h0000, amp_enable}, 16'h0000);
    rc(ADDR_CONDITION, (i == 2) ? 8'hC0 : 8'h08 >> i);
    {overcurrent_in, overheat_fault_in, regulator_undervolt_in, power_stage_undervolt_in} = 4'h0;
    cyc(10);
    chk({15'h0000, amp_enable}, {15'h0000, en});
  endtask
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #2000000;
    err_total++;
    end_sim;
  end
  initial
  begin
    logic [7:0]  lv, m;
    logic [15:0] s;
    logic [16:0] c;
    int          n;
    void'($urandom(32'h909f4757));
    temp_code_in = 8'($urandom);
    supply_code_in = 8'($urandom);
    cyc(5);
    rst_b = 1'b1;
    cyc(3);
    for (int a = 8'h11; a <= 8'h13; a++) wr(a[7:0], 8'hA5);
    rc(ADDR_CLIP_LEVEL, RST_CLIP_LEVEL);
    rc(ADDR_FAULT_CTRL, RST_FAULT_CTRL);
    rc(ADDR_CONDITION, 8'h00);
    rc(ADDR_TEMPERATURE, temp_code_in);
    rc(ADDR_SUPPLY, supply_code_in);
    rc(8'h14, 8'h00);
    m = 8'($urandom);
    wr(ADDR_FAULT_CTRL, m);
    rc(ADDR_FAULT_CTRL, m & 8'hDF);
    limiter_active_in = 1'b1;
    low_battery_in = 1'b1;
    cyc(8);
    rc(ADDR_CONDITION, 8'h21);
    {limiter_active_in, low_battery_in} = 2'b00;
    overheat_warning_in = 1'b1;
    for (int g = 0; g < 4; g++)
    begin
      wr(ADDR_FAULT_CTRL, {2'(g), 6'h18});
      cyc(8);
      chk({10'h000, gain_cut_eighth_db}, {10'h000, cut(g)});
      rc(ADDR_CONDITION, {2'b00, g != 0, 5'h02});
    end
    overheat_warning_in = 1'b0;
    cyc(8);
    for (int i = 0; i < 40; i++)
    begin
      lv = (i < 4) ? 8'h00 : 8'($urandom);
      s = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h00FE : (i == 2) ? 16'h8000 : 16'($urandom);
      if (i == 3) s = 16'h007F;
      c = clipf(lv, s);
      wr(ADDR_CLIP_LEVEL, lv);
      sample_in = s;
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
      chk(sample_out, c[15:0]);
      rc(ADDR_CONDITION, {3'b000, c[16], 4'h0});
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_FAULT_CTRL, 8'h00);
      ep(i, 1'b1);
      ep(i, 1'b0);
      pulses = 0;
      wr(ADDR_FAULT_CTRL, 8'h20);
      cyc(8);
      chk({15'h0000, amp_enable}, 16'h0001);
      m = 8'h18 | (8'h01 << i);
      wr(ADDR_FAULT_CTRL, m);
      ep(i, 1'b0);
      wr(ADDR_FAULT_CTRL, m);
      cyc(8);
      chk({15'h0000, amp_enable}, 16'h0000);
      pulses = 0;
      wr(ADDR_FAULT_CTRL, m | 8'h20);
      cyc(8);
      chk({15'h0000, amp_enable}, 16'h0001);
      chk(16'(pulses), 16'h0001);
    end
    // auto retry limits on the overcurrent fault: three, seven, then unlimited
    for (int r = 0; r < 3; r++)
    begin
      n = (r == 0) ? int'(RETRY_CNT_01) : (r == 1) ? int'(RETRY_CNT_10) : 9;
      wr(ADDR_FAULT_CTRL, {3'b000, 2'(r + 1), 3'b000});
      for (int k = 0; k < n; k++) ep(0, 1'b1);
      ep(0, r == 2);
      wr(ADDR_FAULT_CTRL, {3'b001, 2'(r + 1), 3'b000});
      cyc(8);
      chk({15'h0000, amp_enable}, 16'h0001);
    end
    end_sim;
  end
endmodule
`default_nettype wire

/* rtl/afsr_pkg.sv */
// afsr_pkg: register map, field positions, reset values and codes for the
// amplifier fault and status register bank.
// assumes an 8-bit register port driven by the control interface decoder.
`default_nettype none
package afsr_pkg;
  localparam logic [7:0] ADDR_CLIP_LEVEL  = 8'h0F;
  localparam logic [7:0] ADDR_FAULT_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_CONDITION   = 8'h11;
  localparam logic [7:0] ADDR_TEMPERATURE = 8'h12;
  localparam logic [7:0] ADDR_SUPPLY      = 8'h13;
  localparam logic [7:0] RST_CLIP_LEVEL   = 8'hFF;
  localparam logic [7:0] RST_FAULT_CTRL   = 8'h18;
  // fault control fields
  localparam int unsigned FC_GAIN_HI  = 7;
  localparam int unsigned FC_GAIN_LO  = 6;
  localparam int unsigned FC_MANUAL   = 5;
  localparam int unsigned FC_RETRY_HI = 4;
  localparam int unsigned FC_RETRY_LO = 3;
  localparam int unsigned FC_SEL_UV   = 2;
  localparam int unsigned FC_SEL_OT   = 1;
  localparam int unsigned FC_SEL_OC   = 0;
  // condition flag positions
  localparam int unsigned ST_REG_UV   = 7;
  localparam int unsigned ST_PWR_UV   = 6;
  localparam int unsigned ST_GAIN_RED = 5;
  localparam int unsigned ST_CLIP     = 4;
  localparam int unsigned ST_OC       = 3;
  localparam int unsigned ST_OT_FAULT = 2;
  localparam int unsigned ST_OT_WARN  = 1;
  localparam int unsigned ST_LOW_BAT  = 0;
  // retry limit: number of automatic attempts per code, 0 marks unlimited
  localparam logic [2:0] RETRY_CNT_00 = 3'h1;
  localparam logic [2:0] RETRY_CNT_01 = 3'h3;
  localparam logic [2:0] RETRY_CNT_10 = 3'h7;
  // gain cut in 1/8 dB steps: 0, 1.5, 3, 5.625 dB
  localparam logic [5:0] CUT_00 = 6'h00;
  localparam logic [5:0] CUT_01 = 6'h0C;
  localparam logic [5:0] CUT_10 = 6'h18;
  localparam logic [5:0] CUT_11 = 6'h2D;
  // temperature code offset in degrees and supply scale in volts
  localparam int unsigned TEMP_OFFSET_C = 60;
  localparam int unsigned SUPPLY_BASE_V = 4;
  localparam int unsigned SUPPLY_SPAN_V = 14;
  localparam int unsigned SUPPLY_FULL   = 255;
  localparam int unsigned NFAULT = 3;
endpackage
`default_nettype wire

/* rtl/afsr_regs.sv */
// afsr_regs: clip level, fault recovery control, condition flags and
// sensor readouts of a mono class D amplifier.
// assumes a decoded one-cycle register write/read port on clk; fault and
// sensor inputs come from analog blocks and are synchronised here; sample inputs are used unsynchronised.
`default_nettype none
module afsr_regs
  import afsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic        regulator_undervolt_in,
  input  wire logic        power_stage_undervolt_in,
  input  wire logic        overcurrent_in,
  input  wire logic        overheat_fault_in,
  input  wire logic        overheat_warning_in,
  input  wire logic        limiter_active_in,
  input  wire logic        low_battery_in,
  input  wire logic [7:0]  temp_code_in,
  input  wire logic [7:0]  supply_code_in,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_in,
  output logic [15:0]      sample_out,
  output logic [5:0]       gain_cut_eighth_db,
  output logic             amp_enable,
  output logic             retry_strobe
);
  import afsr_pkg::*;

  localparam int unsigned NSYNC = 7;
  localparam int unsigned TRY_W = 3 * NFAULT;

  typedef struct packed {
    logic [NSYNC-1:0]  s1;
    logic [NSYNC-1:0]  s2;
    logic [NSYNC-1:0]  s3;
    logic [NSYNC-1:0]  lvl;
    logic [15:0]       code_s1;
    logic [15:0]       code_s2;
    logic [15:0]       code_s3;
    logic [7:0]        temp_r;
    logic [7:0]        supply_r;
    logic [7:0]        clip_level;
    logic [7:0]        fault_ctrl;
    logic              clip_seen;
    logic [NFAULT-1:0] latched;
    logic [NFAULT-1:0] stuck;
    // three bits per fault; only a manual trigger rewinds a count
    logic [TRY_W-1:0]  tries;
    logic [15:0]       sample_q;
    logic [5:0]        cut_q;
    logic [7:0]        rdata;
    logic              retry_q;
  } afsr_state_s;

  afsr_state_s st_r;
  afsr_state_s st_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_int_b;
  logic [NSYNC-1:0] raw;
  logic [NFAULT-1:0] fault_now;
  logic [NFAULT-1:0] manual_sel;
  logic        manual_go;
  logic [2:0]  retry_max;
  logic [16:0] clip_mag;
  logic [15:0] mag;
  logic [7:0]  status;

  assign rst_int_b = rst_sync_r[1];
  assign raw = {regulator_undervolt_in, power_stage_undervolt_in, overcurrent_in,
                overheat_fault_in, overheat_warning_in, limiter_active_in, low_battery_in};

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < NSYNC; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
    // multi-bit readouts: a word is taken only once two stages agree, so a
    // code caught mid-change is never shown; a code moving every cycle stalls
    st_nxt.code_s1 = {temp_code_in, supply_code_in};
    st_nxt.code_s2 = st_r.code_s1;
    st_nxt.code_s3 = st_r.code_s2;
    if (st_r.code_s2 == st_r.code_s3)
    begin
      st_nxt.temp_r = st_r.code_s3[15:8];
      st_nxt.supply_r = st_r.code_s3[7:0];
    end

    // lvl bits: 6 reg uv, 5 pwr uv, 4 oc, 3 ot fault, 2 ot warn, 1 limiter, 0 bat
    fault_now = {st_r.lvl[5] | st_r.lvl[6], st_r.lvl[3], st_r.lvl[4]};
    manual_sel = {st_r.fault_ctrl[FC_SEL_UV], st_r.fault_ctrl[FC_SEL_OT],
                  st_r.fault_ctrl[FC_SEL_OC]};

    unique case (st_r.fault_ctrl[FC_RETRY_HI:FC_RETRY_LO])
      2'b00: retry_max = RETRY_CNT_00;
      2'b01: retry_max = RETRY_CNT_01;
      2'b10: retry_max = RETRY_CNT_10;
      2'b11: retry_max = 3'h0;
    endcase

    manual_go = reg_wr && reg_addr == ADDR_FAULT_CTRL && reg_wdata[FC_MANUAL];
    st_nxt.retry_q = 1'b0;

    // fault latch: set wins; released by auto attempt or manual trigger
    for (int f = 0; f < NFAULT; f++)
    begin
      if (fault_now[f])
      begin
        st_nxt.latched[f] = 1'b1;
      end
      else if (st_r.latched[f])
      begin
        if (manual_sel[f] || st_r.stuck[f])
        begin
          if (manual_go)
          begin
            st_nxt.latched[f] = 1'b0;
            st_nxt.stuck[f] = 1'b0;
            st_nxt.tries[3*f +: 3] = 3'h0;
            st_nxt.retry_q = 1'b1;
          end
        end
        else if (retry_max == 3'h0 || st_r.tries[3*f +: 3] < retry_max)
        begin
          st_nxt.latched[f] = 1'b0;
          st_nxt.retry_q = 1'b1;
          if (retry_max != 3'h0)
          begin
            st_nxt.tries[3*f +: 3] = st_r.tries[3*f +: 3] + 3'h1;
          end
        end
        else
        begin
          st_nxt.stuck[f] = 1'b1;
        end
      end
    end

    // gain cut only while the warning is present
    if (st_r.lvl[2])
    begin
      unique case (st_r.fault_ctrl[FC_GAIN_HI:FC_GAIN_LO])
        2'b00: st_nxt.cut_q = CUT_00;
        2'b01: st_nxt.cut_q = CUT_01;
        2'b10: st_nxt.cut_q = CUT_10;
        2'b11: st_nxt.cut_q = CUT_11;
      endcase
    end
    else
    begin
      st_nxt.cut_q = CUT_00;
    end

    // clip to (level+1)/256 of the signed full scale of 2^15, on magnitude, sign kept;
    // limit sits one below that step, so at all-ones -32768 still clips to -32767
    clip_mag = {2'b00, st_r.clip_level, 7'h00} + 17'h00080;
    mag = sample_in[15] ? 16'(-sample_in) : sample_in;
    if (sample_valid)
    begin
      if ({1'b0, mag} > clip_mag - 17'h00001)
      begin
        st_nxt.sample_q = sample_in[15] ? 16'(-(clip_mag - 17'h00001))
                                        : 16'(clip_mag - 17'h00001);
        st_nxt.clip_seen = 1'b1;
      end
      else
      begin
        st_nxt.sample_q = sample_in;
        st_nxt.clip_seen = 1'b0;
      end
    end

    status = 8'h00;
    status[ST_REG_UV] = st_r.lvl[6];
    status[ST_PWR_UV] = st_r.lvl[5];
    status[ST_GAIN_RED] = st_r.lvl[1] | (st_r.cut_q != CUT_00);
    status[ST_CLIP] = st_r.clip_seen;
    status[ST_OC] = st_r.latched[0];
    status[ST_OT_FAULT] = st_r.latched[1];
    status[ST_OT_WARN] = st_r.lvl[2];
    status[ST_LOW_BAT] = st_r.lvl[0];

    if (reg_wr)
    begin
      if (reg_addr == ADDR_CLIP_LEVEL)
      begin
        st_nxt.clip_level = reg_wdata;
      end
      else if (reg_addr == ADDR_FAULT_CTRL)
      begin
        st_nxt.fault_ctrl = reg_wdata;
        st_nxt.fault_ctrl[FC_MANUAL] = 1'b0;
      end
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CLIP_LEVEL:  st_nxt.rdata = st_r.clip_level;
        ADDR_FAULT_CTRL:  st_nxt.rdata = st_r.fault_ctrl;
        ADDR_CONDITION:   st_nxt.rdata = status;
        ADDR_TEMPERATURE: st_nxt.rdata = st_r.temp_r;
        ADDR_SUPPLY:      st_nxt.rdata = st_r.supply_r;
        default:          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_r <= 2'b00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_int_b)
  begin
    if (!rst_int_b)
    begin
      st_r.s1 <= '0;
      st_r.s2 <= '0;
      st_r.s3 <= '0;
      st_r.lvl <= '0;
      st_r.code_s1 <= 16'h0000;
      st_r.code_s2 <= 16'h0000;
      st_r.code_s3 <= 16'h0000;
      st_r.temp_r <= 8'h00;
      st_r.supply_r <= 8'h00;
      st_r.clip_level <= RST_CLIP_LEVEL;
      st_r.fault_ctrl <= RST_FAULT_CTRL;
      st_r.clip_seen <= 1'b0;
      st_r.latched <= '0;
      st_r.stuck <= '0;
      st_r.tries <= '0;
      st_r.sample_q <= 16'h0000;
      st_r.cut_q <= CUT_00;
      st_r.rdata <= 8'h00;
      st_r.retry_q <= 1'b0;
    end
    else
    begin
      st_r.s1 <= st_nxt.s1;
      st_r.s2 <= st_nxt.s2;
      st_r.s3 <= st_nxt.s3;
      st_r.lvl <= st_nxt.lvl;
      st_r.code_s1 <= st_nxt.code_s1;
      st_r.code_s2 <= st_nxt.code_s2;
      st_r.code_s3 <= st_nxt.code_s3;
      st_r.temp_r <= st_nxt.temp_r;
      st_r.supply_r <= st_nxt.supply_r;
      st_r.clip_level <= st_nxt.clip_level;
      st_r.fault_ctrl <= st_nxt.fault_ctrl;
      st_r.clip_seen <= st_nxt.clip_seen;
      st_r.latched <= st_nxt.latched;
      st_r.stuck <= st_nxt.stuck;
      st_r.tries <= st_nxt.tries;
      st_r.sample_q <= st_nxt.sample_q;
      st_r.cut_q <= st_nxt.cut_q;
      st_r.rdata <= st_nxt.rdata;
      st_r.retry_q <= st_nxt.retry_q;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign sample_out = st_r.sample_q;
  assign gain_cut_eighth_db = st_r.cut_q;
  // output stays off while any fault is latched or stuck
  assign amp_enable = ~|st_r.latched;
  assign retry_strobe = st_r.retry_q;
endmodule
`default_nettype wire
